// ===== core/erc_regs.vh
// constants for the endurance region configuration bank
// assumes a single clock and plain verilog-2005 includes
//
// Overview of operation
// - nine-bit start sector, factory value all ones
// - region type: 0 retention, 1 endurance
// - active-low pointer enable, ships disabled
// - enable bit0, type bit1, start 10:2
// - global region type at base bit1
// - global type covers all when pointers off
// - wear levelling enable at base bit0
// - all fields nonvolatile and readable
// - pointers three and four share layout
`ifndef ERC_REGS_VH
`define ERC_REGS_VH

`define ERC_REG_W        11
`define ERC_SECT_W       9
`define ERC_IDX_W        3
`define ERC_NPTR         5

`define ERC_IDX_BASE     3'h0
`define ERC_IDX_PTR1     3'h1
`define ERC_IDX_PTR2     3'h2
`define ERC_IDX_PTR3     3'h3
`define ERC_IDX_PTR4     3'h4

`define ERC_DIS_BIT      0
`define ERC_TYPE_BIT     1
`define ERC_START_MSB    10
`define ERC_START_LSB    2

`define ERC_WEAR_BIT     0
`define ERC_GLOBAL_BIT   1
`define ERC_BASE_MASK    11'h003

`define ERC_PTR_RST      11'h7ff
`define ERC_BASE_RST     11'h003
`define ERC_START_RST    9'h1ff
`define ERC_WEAR_RST     1'b1
`define ERC_GLOBAL_RST   1'b1
`define ERC_TYPE_RST     1'b1
`define ERC_DIS_RST      1'b1

`define ERC_SEL_GLOBAL   3'h0

`endif

// ===== core/erc_classify.v
// region class lookup for one sector against pointers one to four
// assumes the four pointer words arrive packed, pointer one lowest
`include "erc_regs.vh"

module erc_classify (
  input  wire [`ERC_SECT_W-1:0]  sector,
  input  wire [4*`ERC_REG_W-1:0] ptr_bus,
  input  wire                    global_type,
  output reg                     high_end,
  output reg  [`ERC_IDX_W-1:0]   ptr_sel
);

  function hit;
    input [`ERC_REG_W-1:0]  cfg;
    input [`ERC_SECT_W-1:0] sec;
    begin
      hit = (cfg[`ERC_DIS_BIT] == 1'b0) &&
            (cfg[`ERC_START_MSB:`ERC_START_LSB] <= sec);
    end
  endfunction

  integer                 i;
  reg [`ERC_REG_W-1:0]    cfg;
  reg [`ERC_SECT_W-1:0]   best;
  reg                     found;

  always @* begin
    cfg      = {`ERC_REG_W{1'b0}};
    best     = {`ERC_SECT_W{1'b0}};
    found    = 1'b0;
    high_end = global_type;
    ptr_sel  = `ERC_SEL_GLOBAL;
    for (i = 0; i < 4; i = i + 1) begin
      cfg = ptr_bus[i*`ERC_REG_W +: `ERC_REG_W];
      // ties go to the higher numbered pointer
      if (hit(cfg, sector) &&
          (!found || cfg[`ERC_START_MSB:`ERC_START_LSB] >= best)) begin
        found    = 1'b1;
        best     = cfg[`ERC_START_MSB:`ERC_START_LSB];
        high_end = cfg[`ERC_TYPE_BIT];
        ptr_sel  = i[`ERC_IDX_W-1:0] + 3'h1;
      end
    end
  end

endmodule

// ===== core/erc_bank.v
// endurance region configuration bank with sector class lookup
// assumes the serial command engine drives the register port
// and that factory_load stands in for the factory programming step
`include "erc_regs.vh"

module erc_bank (
  input  wire                   clock,
  input  wire                   sys_rst,
  input  wire                   factory_load,
  input  wire [`ERC_IDX_W-1:0]  reg_addr,
  input  wire                   reg_wr,
  input  wire [`ERC_REG_W-1:0]  reg_wdata,
  input  wire                   reg_rd,
  input  wire [`ERC_SECT_W-1:0] sector_addr,
  input  wire                   sector_query,
  output reg  [`ERC_REG_W-1:0]  reg_rdata_r,
  output reg                    reg_rvalid_r,
  output reg                    reg_err_r,
  output reg                    wear_level_on_r,
  output reg                    global_region_type_r,
  output reg  [`ERC_SECT_W-1:0] ptr1_start_sector_r,
  output reg                    ptr1_region_type_r,
  output reg                    ptr1_disable_n_r,
  output reg  [`ERC_SECT_W-1:0] ptr2_start_sector_r,
  output reg                    ptr2_region_type_r,
  output reg                    ptr2_disable_n_r,
  output reg  [`ERC_SECT_W-1:0] ptr3_start_sector_r,
  output reg                    ptr3_region_type_r,
  output reg                    ptr3_disable_n_r,
  output reg  [`ERC_SECT_W-1:0] ptr4_start_sector_r,
  output reg                    ptr4_region_type_r,
  output reg                    ptr4_disable_n_r,
  output reg                    class_valid_r,
  output reg                    class_high_end_r,
  output reg  [`ERC_IDX_W-1:0]  class_ptr_r
);

  // legal index check, shared by read and write paths
  function idx_ok;
    input [`ERC_IDX_W-1:0] idx;
    begin
      idx_ok = (idx <= `ERC_IDX_PTR4);
    end
  endfunction

  // base word keeps only its two low bits
  function [`ERC_REG_W-1:0] fit;
    input [`ERC_IDX_W-1:0] idx;
    input [`ERC_REG_W-1:0] val;
    begin
      if (idx == `ERC_IDX_BASE)
        fit = val & `ERC_BASE_MASK;
      else
        fit = val;
    end
  endfunction

  // field pickers for one pointer word
  function [`ERC_SECT_W-1:0] start_of;
    input [`ERC_REG_W-1:0] w;
    begin
      start_of = w[`ERC_START_MSB:`ERC_START_LSB];
    end
  endfunction

  function type_of;
    input [`ERC_REG_W-1:0] w;
    begin
      type_of = w[`ERC_TYPE_BIT];
    end
  endfunction

  function dis_of;
    input [`ERC_REG_W-1:0] w;
    begin
      dis_of = w[`ERC_DIS_BIT];
    end
  endfunction

  // nonvolatile cells: untouched by sys_rst, survive device resets
  reg  [`ERC_REG_W-1:0]   cell_mem [0:`ERC_NPTR-1];
  integer                 k;
  // factory load wins over a host write in the same cycle
  wire                    wr_ok = reg_wr && idx_ok(reg_addr) && !factory_load;

  always @(posedge clock) begin
    if (factory_load) begin
      cell_mem[`ERC_IDX_BASE] <= `ERC_BASE_RST;
      for (k = 1; k < `ERC_NPTR; k = k + 1) begin
        cell_mem[k] <= `ERC_PTR_RST;
      end
    end else if (wr_ok) begin
      cell_mem[reg_addr] <= fit(reg_addr, reg_wdata);
    end
  end

  // register read path, one cycle latency
  reg  [`ERC_REG_W-1:0]   rdata_nxt;
  // unmapped index: write dropped, read answers zero
  wire                    acc_bad = (reg_rd || reg_wr) && !idx_ok(reg_addr);

  always @* begin
    rdata_nxt = {`ERC_REG_W{1'b0}};
    if (idx_ok(reg_addr))
      rdata_nxt = fit(reg_addr, cell_mem[reg_addr]);
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata_r  <= {`ERC_REG_W{1'b0}};
      reg_rvalid_r <= 1'b0;
      reg_err_r    <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      reg_err_r    <= acc_bad;
      // read data holds until the next read
      if (reg_rd)
        reg_rdata_r <= rdata_nxt;
    end
  end

  // decoded fields mirror the cells one cycle behind
  wire [`ERC_REG_W-1:0]   base_w = cell_mem[`ERC_IDX_BASE];
  wire [`ERC_REG_W-1:0]   p1_w   = cell_mem[`ERC_IDX_PTR1];
  wire [`ERC_REG_W-1:0]   p2_w   = cell_mem[`ERC_IDX_PTR2];
  wire [`ERC_REG_W-1:0]   p3_w   = cell_mem[`ERC_IDX_PTR3];
  wire [`ERC_REG_W-1:0]   p4_w   = cell_mem[`ERC_IDX_PTR4];

  always @(posedge clock) begin
    if (sys_rst) begin
      wear_level_on_r      <= `ERC_WEAR_RST;
      global_region_type_r <= `ERC_GLOBAL_RST;
    end else begin
      wear_level_on_r      <= base_w[`ERC_WEAR_BIT];
      global_region_type_r <= base_w[`ERC_GLOBAL_BIT];
    end
  end

  // pointer words show factory values while in reset
  always @(posedge clock) begin
    if (sys_rst) begin
      ptr1_start_sector_r <= `ERC_START_RST;
      ptr1_region_type_r  <= `ERC_TYPE_RST;
      ptr1_disable_n_r    <= `ERC_DIS_RST;
    end else begin
      ptr1_start_sector_r <= start_of(p1_w);
      ptr1_region_type_r  <= type_of(p1_w);
      ptr1_disable_n_r    <= dis_of(p1_w);
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      ptr2_start_sector_r <= `ERC_START_RST;
      ptr2_region_type_r  <= `ERC_TYPE_RST;
      ptr2_disable_n_r    <= `ERC_DIS_RST;
    end else begin
      ptr2_start_sector_r <= start_of(p2_w);
      ptr2_region_type_r  <= type_of(p2_w);
      ptr2_disable_n_r    <= dis_of(p2_w);
    end
  end

  // pointers three and four share the same layout
  always @(posedge clock) begin
    if (sys_rst) begin
      ptr3_start_sector_r <= `ERC_START_RST;
      ptr3_region_type_r  <= `ERC_TYPE_RST;
      ptr3_disable_n_r    <= `ERC_DIS_RST;
    end else begin
      ptr3_start_sector_r <= start_of(p3_w);
      ptr3_region_type_r  <= type_of(p3_w);
      ptr3_disable_n_r    <= dis_of(p3_w);
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      ptr4_start_sector_r <= `ERC_START_RST;
      ptr4_region_type_r  <= `ERC_TYPE_RST;
      ptr4_disable_n_r    <= `ERC_DIS_RST;
    end else begin
      ptr4_start_sector_r <= start_of(p4_w);
      ptr4_region_type_r  <= type_of(p4_w);
      ptr4_disable_n_r    <= dis_of(p4_w);
    end
  end

  // sector lookup uses the mirrored fields, not the raw cells
  wire [4*`ERC_REG_W-1:0] ptr_bus;
  wire                    hit_high_end;
  wire [`ERC_IDX_W-1:0]   hit_sel;

  assign ptr_bus = {ptr4_start_sector_r, ptr4_region_type_r, ptr4_disable_n_r,
                    ptr3_start_sector_r, ptr3_region_type_r, ptr3_disable_n_r,
                    ptr2_start_sector_r, ptr2_region_type_r, ptr2_disable_n_r,
                    ptr1_start_sector_r, ptr1_region_type_r, ptr1_disable_n_r};

  erc_classify u_classify (
    .sector      (sector_addr),
    .ptr_bus     (ptr_bus),
    .global_type (global_region_type_r),
    .high_end    (hit_high_end),
    .ptr_sel     (hit_sel)
  );

  always @(posedge clock) begin
    if (sys_rst) begin
      class_valid_r    <= 1'b0;
      class_high_end_r <= 1'b0;
      class_ptr_r      <= `ERC_SEL_GLOBAL;
    end else begin
      class_valid_r <= sector_query;
      // class holds between queries
      if (sector_query) begin
        class_high_end_r <= hit_high_end;
        class_ptr_r      <= hit_sel;
      end
    end
  end

endmodule

// ===== test/erc_bank_assertions.sv
// port-level checks for the region configuration bank
// assumes bind onto erc_bank, one clock, sync reset
`include "erc_regs.vh"
module erc_bank_assertions (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        factory_load,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [2:0]  reg_addr,
  input wire logic [2:0]  class_ptr_r,
  input wire logic [10:0] reg_wdata,
  input wire logic [10:0] reg_rdata_r,
  input wire logic        sector_query,
  input wire logic        reg_rvalid_r,
  input wire logic        reg_err_r,
  input wire logic        wear_level_on_r,
  input wire logic        global_region_type_r,
  input wire logic        class_valid_r,
  input wire logic        class_high_end_r,
  input wire logic        ptr1_disable_n_r,
  input wire logic        ptr2_disable_n_r,
  input wire logic        ptr3_disable_n_r,
  input wire logic        ptr4_disable_n_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire all_off = ptr1_disable_n_r & ptr2_disable_n_r & ptr3_disable_n_r
                 & ptr4_disable_n_r;
  sequence s_factory; factory_load ##1 1'b1; endsequence
  sequence s_wr1; reg_wr && reg_addr == 3'h1 && !factory_load; endsequence
  read_answer_a: assert property (reg_rd |=> reg_rvalid_r)
    else $error("read not answered");
  answer_cause_a: assert property (reg_rvalid_r |-> $past(reg_rd))
    else $error("answer without read");
  unmapped_flag_a: assert property ((reg_rd || reg_wr) && reg_addr > 3'h4
    |=> reg_err_r) else $error("unmapped access not flagged");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 3'h4
    |=> reg_rdata_r == 11'h000) else $error("unmapped read not zero");
  base_width_a: assert property (reg_rd && reg_addr == 3'h0
    |=> reg_rdata_r[10:2] == 9'h000) else $error("base upper bits set");
  factory_fields_a: assert property (s_factory |=> wear_level_on_r
    && global_region_type_r && ptr1_disable_n_r) else $error("bad factory");
  ptr_decode_a: assert property (s_wr1 |-> ##2
    ptr1_disable_n_r == $past(reg_wdata[0], 2)) else $error("bad enable bit");
  query_answer_a: assert property (sector_query |=> class_valid_r)
    else $error("query not answered");
  global_rule_a: assert property (sector_query && all_off |=>
    class_ptr_r == 3'h0 && class_high_end_r == $past(global_region_type_r))
    else $error("global type not used");
endmodule
bind erc_bank erc_bank_assertions chk (
  .clock(clock), .sys_rst(sys_rst), .factory_load(factory_load),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .class_ptr_r(class_ptr_r), .reg_wdata(reg_wdata),
  .reg_rdata_r(reg_rdata_r), .sector_query(sector_query),
  .reg_rvalid_r(reg_rvalid_r), .reg_err_r(reg_err_r),
  .wear_level_on_r(wear_level_on_r),
  .global_region_type_r(global_region_type_r),
  .class_valid_r(class_valid_r), .class_high_end_r(class_high_end_r),
  .ptr1_disable_n_r(ptr1_disable_n_r), .ptr2_disable_n_r(ptr2_disable_n_r),
  .ptr3_disable_n_r(ptr3_disable_n_r), .ptr4_disable_n_r(ptr4_disable_n_r));

// ===== test/erc_bank_tb.sv
// self-checking bench for the region configuration bank
// assumes erc_bank with its checker bound in
`include "erc_regs.vh"
module erc_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, sys_rst = 1'b1, factory_load = 1'b1;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, sector_query = 1'b0;
  logic [2:0]  reg_addr = 3'h0, class_ptr_r;
  logic [10:0] reg_wdata = 11'h000, reg_rdata_r;
  logic [8:0]  sector_addr = 9'h000, ptr1_start_sector_r, ptr2_start_sector_r;
  logic [8:0]  ptr3_start_sector_r, ptr4_start_sector_r;
  logic        reg_rvalid_r, reg_err_r, wear_level_on_r, global_region_type_r;
  logic        ptr1_region_type_r, ptr2_region_type_r, ptr3_region_type_r;
  logic        ptr4_region_type_r, ptr1_disable_n_r, ptr2_disable_n_r;
  logic        ptr3_disable_n_r, ptr4_disable_n_r, class_valid_r;
  logic        class_high_end_r;
  wire  [10:0] ptr1_word = {ptr1_start_sector_r, ptr1_region_type_r,
                            ptr1_disable_n_r};
  wire  [10:0] ptr2_word = {ptr2_start_sector_r, ptr2_region_type_r,
                            ptr2_disable_n_r};
  wire  [10:0] ptr3_word = {ptr3_start_sector_r, ptr3_region_type_r,
                            ptr3_disable_n_r};
  wire  [10:0] ptr4_word = {ptr4_start_sector_r, ptr4_region_type_r,
                            ptr4_disable_n_r};
  int          miscompares = 0, samples_checked = 0;
  typedef struct packed {
    logic [2:0] a; logic [10:0] d, rd; logic [8:0] s; logic h; logic [2:0] p;
  } erc_row_t;
  // write, read back, then classify one sector against the new state
  erc_row_t rows [8] = '{
    '{3'h0, 11'h7fc, 11'h000, 9'h005, 1'b0, 3'h0},
    '{3'h1, 11'h042, 11'h042, 9'h010, 1'b1, 3'h1},
    '{3'h2, 11'h080, 11'h080, 9'h01f, 1'b1, 3'h1},
    '{3'h3, 11'h0c3, 11'h0c3, 9'h040, 1'b0, 3'h2},
    '{3'h4, 11'h0c2, 11'h0c2, 9'h030, 1'b1, 3'h4},
    '{3'h5, 11'h555, 11'h000, 9'h00f, 1'b0, 3'h0},
    '{3'h3, 11'h0c0, 11'h0c0, 9'h1ff, 1'b1, 3'h4},
    '{3'h0, 11'h003, 11'h003, 9'h000, 1'b1, 3'h0}};
  erc_bank uut (
    .clock(clock), .sys_rst(sys_rst), .factory_load(factory_load),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .sector_addr(sector_addr),
    .sector_query(sector_query), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .reg_err_r(reg_err_r),
    .wear_level_on_r(wear_level_on_r),
    .global_region_type_r(global_region_type_r),
    .ptr1_start_sector_r(ptr1_start_sector_r),
    .ptr1_region_type_r(ptr1_region_type_r),
    .ptr1_disable_n_r(ptr1_disable_n_r),
    .ptr2_start_sector_r(ptr2_start_sector_r),
    .ptr2_region_type_r(ptr2_region_type_r),
    .ptr2_disable_n_r(ptr2_disable_n_r),
    .ptr3_start_sector_r(ptr3_start_sector_r),
    .ptr3_region_type_r(ptr3_region_type_r),
    .ptr3_disable_n_r(ptr3_disable_n_r),
    .ptr4_start_sector_r(ptr4_start_sector_r),
    .ptr4_region_type_r(ptr4_region_type_r),
    .ptr4_disable_n_r(ptr4_disable_n_r),
    .class_valid_r(class_valid_r), .class_high_end_r(class_high_end_r),
    .class_ptr_r(class_ptr_r));
  initial forever #12.5 clock = ~clock;
  task automatic chk(input logic [10:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic txn(input logic w, r, q, input logic [2:0] a,
                     input logic [10:0] d, input logic [8:0] s);
    @(negedge clock);
    {reg_wr, reg_rd, sector_query, reg_addr, reg_wdata, sector_addr} =
      {w, r, q, a, d, s};
    @(negedge clock);
    {reg_wr, reg_rd, sector_query} = 3'b000;
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clock);
    {sys_rst, factory_load} = 2'b00;
    foreach (rows[i]) begin
      txn(1'b1, 1'b0, 1'b0, rows[i].a, rows[i].d, 9'h000);
      txn(1'b0, 1'b1, 1'b0, rows[i].a, 11'h000, 9'h000);
      chk(reg_rdata_r, rows[i].rd);
      chk(reg_rvalid_r, 1'b1);
      chk(reg_err_r, rows[i].a > 3'h4);
      txn(1'b0, 1'b0, 1'b1, 3'h0, 11'h000, rows[i].s);
      chk({class_high_end_r, class_ptr_r}, {rows[i].h, rows[i].p});
      chk(class_valid_r, 1'b1);
    end
    chk(ptr4_word, 11'h0c2);
    chk(ptr3_word, 11'h0c0);
    chk(ptr2_word, 11'h080);
    // read in the same cycle as a write sees the old word
    txn(1'b1, 1'b1, 1'b0, 3'h1, 11'h7ff, 9'h000);
    chk(reg_rdata_r, 11'h042);
    txn(1'b1, 1'b0, 1'b0, 3'h0, 11'h001, 9'h000);
    chk(ptr1_word, 11'h7ff);
    txn(1'b0, 1'b0, 1'b0, 3'h0, 11'h000, 9'h000);
    chk({global_region_type_r, wear_level_on_r}, 2'b01);
    {sys_rst, factory_load} = 2'b11;
    repeat (2) @(negedge clock);
    chk({reg_rvalid_r, class_valid_r, wear_level_on_r}, 3'b001);
    chk(reg_rdata_r, 11'h000);
    sys_rst = 1'b0;
    // a host write while factory load stays high is dropped
    txn(1'b1, 1'b0, 1'b0, 3'h2, 11'h000, 9'h000);
    factory_load = 1'b0;
    for (int i = 0; i < 5; i++) begin
      txn(1'b0, 1'b1, 1'b0, 3'(i), 11'h000, 9'h000);
      chk(reg_rdata_r, (i == 0) ? 11'h003 : 11'h7ff);
    end
    txn(1'b0, 1'b0, 1'b1, 3'h0, 11'h000, 9'h1ff);
    chk({class_high_end_r, class_ptr_r}, 4'h8);
    summarize();
  end
  initial begin
    repeat (600) @(posedge clock);
    miscompares++;
    summarize();
  end
endmodule
